/* verilog/fpr_regs.sv */
// Register slice: front-end gain, buffer pointers, packet start and masks.
// Assumes the serial interface presents one-cycle read and write strobes
// and that the modem reports events and packet starts as one-cycle pulses.
`default_nettype none
`timescale 1ns/100ps

// Notes on behaviour
// - Gain field selects steps G1 to G6
// - Gain resets to maximum step, host RW
// - Low-band current resets to default, others reserved
// - High-band current default; code 11 boosts
// - Host pointer RW, resets zero, addresses buffer
// - Transmit base RW, resets to 0x80
// - Receive base RW, resets to zero
// - Last packet start read-only, writes ignored
// - Mask bit 7 suppresses receive timeout
// - Mask bit 6 suppresses reception complete
// - Mask bit 5 suppresses payload check error
// - Mask bit 4 suppresses good header
// - Mask bit 3 suppresses transmission complete
// - Mask bit 2 suppresses activity scan done
// - Mask bit 1 suppresses hop request
// - Mask bit 0 suppresses activity found
// - Flags align with masks; write one clears
module fpr_regs
    import fpr_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_rst_b,
    input  wire fpr_req_t      i_req,
    input  wire logic          i_buf_access,
    input  wire logic          i_rx_pkt_start,
    input  wire logic [7:0]    i_rx_pkt_addr,
    input  wire fpr_irq_t      i_irq_event,
    output logic [7:0]         o_rdata,
    output logic               o_rdata_valid,
    output logic [2:0]         o_front_end_gain_step,
    output logic               o_high_band_boost,
    output logic [7:0]         o_host_buffer_pointer,
    output logic [7:0]         o_transmit_buffer_base,
    output logic [7:0]         o_receive_buffer_base,
    output fpr_irq_t           o_irq_flags,
    output fpr_irq_t           o_irq_pending,
    output logic               o_irq
);

    fpr_gain_cfg_t gain_q, gain_d;
    logic [7:0]    host_ptr_q, host_ptr_d;
    logic [7:0]    tx_base_q, tx_base_d;
    logic [7:0]    rx_base_q, rx_base_d;
    logic [7:0]    last_pkt_q, last_pkt_d;
    fpr_irq_t      mask_q, mask_d;
    fpr_irq_t      flags_q, flags_d;
    fpr_irq_t      pend_q, pend_d;
    logic          irq_q, irq_d;
    logic [7:0]    rdata_q, rdata_d;
    logic          rvalid_q, rvalid_d;
    logic          boost_q, boost_d;
    logic          wr_gain;
    logic          wr_ptr;
    logic [7:0]    flags_next_bits;
    logic [7:0]    mask_next_bits;
    logic [7:0]    pend_bits;

    assign wr_gain = i_req.wr && (i_req.addr == FPR_ADDR_GAIN_CFG);
    assign wr_ptr  = i_req.wr && (i_req.addr == FPR_ADDR_HOST_PTR);

    // Configuration and pointer registers.
    always_comb begin
        gain_d     = gain_q;
        host_ptr_d = host_ptr_q;
        tx_base_d  = tx_base_q;
        rx_base_d  = rx_base_q;
        last_pkt_d = last_pkt_q;
        mask_d     = mask_q;
        if (wr_gain) begin
            // Unused gain codes are refused so the amplifier only ever
            // sees a valid step; the previous step is kept.
            if (i_req.wdata[7:5] >= FPR_GAIN_MAX &&
                i_req.wdata[7:5] <= FPR_GAIN_MIN) begin
                gain_d.front_end_gain_step = i_req.wdata[7:5];
            end
            gain_d.low_band_current_adjust  = i_req.wdata[4:3];
            gain_d.reserved_bit             = i_req.wdata[2];
            gain_d.high_band_current_adjust = i_req.wdata[1:0];
        end
        // A direct pointer write outranks the advance from a buffer access.
        if (wr_ptr) begin
            host_ptr_d = i_req.wdata;
        end else if (i_buf_access) begin
            host_ptr_d = host_ptr_q + FPR_ONE;
        end
        if (i_req.wr && i_req.addr == FPR_ADDR_TX_BASE) begin
            tx_base_d = i_req.wdata;
        end
        if (i_req.wr && i_req.addr == FPR_ADDR_RX_BASE) begin
            rx_base_d = i_req.wdata;
        end
        if (i_rx_pkt_start) begin
            last_pkt_d = i_rx_pkt_addr;
        end
        if (i_req.wr && i_req.addr == FPR_ADDR_IRQ_MASK) begin
            mask_d = i_req.wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gain_q     <= '{FPR_GAIN_RST, FPR_CUR_DEFAULT, 1'b0,
                            FPR_CUR_DEFAULT};
            host_ptr_q <= FPR_HOST_PTR_RST;
            tx_base_q  <= FPR_TX_BASE_RST;
            rx_base_q  <= FPR_RX_BASE_RST;
            last_pkt_q <= FPR_LAST_PKT_RST;
            mask_q     <= FPR_MASK_RST;
        end else begin
            gain_q     <= gain_d;
            host_ptr_q <= host_ptr_d;
            tx_base_q  <= tx_base_d;
            rx_base_q  <= rx_base_d;
            last_pkt_q <= last_pkt_d;
            mask_q     <= mask_d;
        end
    end

    // Flags, masking and the interrupt line.
    always_comb begin
        flags_d = flags_q;
        if (i_req.wr && i_req.addr == FPR_ADDR_IRQ_FLAGS) begin
            flags_d = flags_q & ~i_req.wdata;
        end
        // An event in the clearing cycle survives the clear.
        flags_d = flags_d | i_irq_event;
        pend_d = pend_bits;
        irq_d  = |pend_bits;
        boost_d = (gain_d.high_band_current_adjust == FPR_HF_BOOST);
    end

    assign flags_next_bits = flags_d;
    assign mask_next_bits  = mask_d;

    // Each mask bit gates only its own flag, so a masked source can never
    // hide or raise another source's request.
    for (genvar b = 0; b < 8; b++) begin : g_pend
        assign pend_bits[b] = flags_next_bits[b] & ~mask_next_bits[b];
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flags_q <= FPR_FLAGS_RST;
            pend_q  <= FPR_FLAGS_RST;
            irq_q   <= 1'b0;
            boost_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            pend_q  <= pend_d;
            irq_q   <= irq_d;
            boost_q <= boost_d;
        end
    end

    // Read path: data registered one cycle after the read strobe.
    always_comb begin
        rvalid_d = i_req.rd;
        rdata_d  = 8'h00;
        if (i_req.rd) begin
            case (i_req.addr)
                FPR_ADDR_GAIN_CFG:  rdata_d = gain_q;
                FPR_ADDR_HOST_PTR:  rdata_d = host_ptr_q;
                FPR_ADDR_TX_BASE:   rdata_d = tx_base_q;
                FPR_ADDR_RX_BASE:   rdata_d = rx_base_q;
                FPR_ADDR_LAST_PKT:  rdata_d = last_pkt_q;
                FPR_ADDR_IRQ_MASK:  rdata_d = mask_q;
                FPR_ADDR_IRQ_FLAGS: rdata_d = flags_q;
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign o_rdata                = rdata_q;
    assign o_rdata_valid          = rvalid_q;
    assign o_front_end_gain_step  = gain_q.front_end_gain_step;
    assign o_high_band_boost      = boost_q;
    assign o_host_buffer_pointer  = host_ptr_q;
    assign o_transmit_buffer_base = tx_base_q;
    assign o_receive_buffer_base  = rx_base_q;
    assign o_irq_flags            = flags_q;
    assign o_irq_pending          = pend_q;
    assign o_irq                  = irq_q;

endmodule // fpr_regs
`default_nettype wire

/* verilog/fpr_pkg.sv */
// Package for the front-end, buffer pointer and interrupt mask register slice.
// Assumes a byte-wide register port decoded by the device's serial interface.
`default_nettype none
package fpr_pkg;
    localparam logic [6:0] FPR_ADDR_GAIN_CFG  = 7'h0C;
    localparam logic [6:0] FPR_ADDR_HOST_PTR  = 7'h0D;
    localparam logic [6:0] FPR_ADDR_TX_BASE   = 7'h0E;
    localparam logic [6:0] FPR_ADDR_RX_BASE   = 7'h0F;
    localparam logic [6:0] FPR_ADDR_LAST_PKT  = 7'h10;
    localparam logic [6:0] FPR_ADDR_IRQ_MASK  = 7'h11;
    localparam logic [6:0] FPR_ADDR_IRQ_FLAGS = 7'h12;

    localparam logic [2:0] FPR_GAIN_RST       = 3'h1;
    localparam logic [2:0] FPR_GAIN_MAX       = 3'h1;
    localparam logic [2:0] FPR_GAIN_MIN       = 3'h6;
    localparam logic [1:0] FPR_CUR_DEFAULT    = 2'h0;
    localparam logic [1:0] FPR_HF_BOOST       = 2'h3;
    localparam logic [7:0] FPR_HOST_PTR_RST   = 8'h00;
    localparam logic [7:0] FPR_TX_BASE_RST    = 8'h80;
    localparam logic [7:0] FPR_RX_BASE_RST    = 8'h00;
    localparam logic [7:0] FPR_LAST_PKT_RST   = 8'h00;
    localparam logic [7:0] FPR_MASK_RST       = 8'h00;
    localparam logic [7:0] FPR_FLAGS_RST      = 8'h00;
    localparam logic [7:0] FPR_ONE            = 8'h01;

    // Gain configuration byte layout.
    typedef struct packed {
        logic [2:0] front_end_gain_step;
        logic [1:0] low_band_current_adjust;
        logic       reserved_bit;
        logic [1:0] high_band_current_adjust;
    } fpr_gain_cfg_t;

    // Interrupt event / flag / mask bit layout, one bit per source.
    typedef struct packed {
        logic receive_timeout;
        logic reception_complete;
        logic payload_check_error;
        logic good_header;
        logic transmission_complete;
        logic activity_scan_done;
        logic hop_request;
        logic activity_found;
    } fpr_irq_t;

    // Register port request from the serial interface.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } fpr_req_t;
endpackage : fpr_pkg
`default_nettype wire

/* sim/fpr_regs_properties.sv */
// Checker for the register slice, bound to the ports of fpr_regs.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module fpr_regs_properties
    import fpr_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst_b,
    input wire fpr_req_t   i_req,
    input wire logic       i_buf_access,
    input wire fpr_irq_t   i_irq_event,
    input wire logic       o_rdata_valid,
    input wire logic [2:0] o_front_end_gain_step,
    input wire logic       o_high_band_boost,
    input wire logic [7:0] o_host_buffer_pointer,
    input wire logic [7:0] o_transmit_buffer_base,
    input wire fpr_irq_t   o_irq_flags,
    input wire fpr_irq_t   o_irq_pending,
    input wire logic       o_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    property p_rv; i_req.rd |=> o_rdata_valid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_nrv; !i_req.rd |=> !o_rdata_valid; endproperty
    a_nrv: assert property (p_nrv) else $error("stray valid");
    property p_gain; o_front_end_gain_step inside {[1:6]}; endproperty
    a_gain: assert property (p_gain) else $error("unused gain code");
    property p_boost; i_req.wr && i_req.addr == FPR_ADDR_GAIN_CFG |=>
        o_high_band_boost == ($past(i_req.wdata[1:0]) == FPR_HF_BOOST);
    endproperty
    a_boost: assert property (p_boost) else $error("boost wrong");
    property p_txb; i_req.wr && i_req.addr == FPR_ADDR_TX_BASE |=>
        o_transmit_buffer_base == $past(i_req.wdata); endproperty
    a_txb: assert property (p_txb) else $error("tx base wrong");
    property p_ptr; i_buf_access && !i_req.wr |=>
        o_host_buffer_pointer == $past(o_host_buffer_pointer) + 8'h01;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer step");
    property p_flag; |i_irq_event |=>
        (o_irq_flags & $past(i_irq_event)) == $past(i_irq_event); endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_pend; ((o_irq_pending & ~o_irq_flags) == 8'h00)
        && (o_irq == |o_irq_pending); endproperty
    a_pend: assert property (p_pend) else $error("pending wrong");
    property p_clr; i_req.wr && i_req.addr == FPR_ADDR_IRQ_FLAGS
        && !(|i_irq_event) |=> (o_irq_flags & $past(i_req.wdata)) == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
endmodule // fpr_regs_properties
bind fpr_regs fpr_regs_properties chk_u (.*);
`default_nettype wire

/* sim/fpr_host_model.sv */
// Host controller model issuing register reads and writes.
// Assumes the answer comes exactly one cycle after the read edge.
`timescale 1ns/100ps
`default_nettype none
module fpr_host_model
    import fpr_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rdata_valid,
    output var  fpr_req_t   o_req
);
    initial o_req = '0;
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clock);
        // Reserved low-band codes are never sent by a well-behaved host.
        if (a == FPR_ADDR_GAIN_CFG) d[4:3] = FPR_CUR_DEFAULT;
        o_req <= '{1'b1, 1'b0, a, d};
        @(posedge i_clock);
        o_req <= '{1'b0, 1'b0, ~a, ~d};
        #1;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge i_clock);
        o_req <= '{1'b0, 1'b1, a, 8'hA5};
        @(posedge i_clock);
        o_req <= '{1'b0, 1'b0, ~a, 8'h5A};
        #1 d = i_rdata;
        v = i_rdata_valid;
    endtask
endmodule // fpr_host_model
`default_nettype wire

/* sim/tb_fpr_regs.sv */
// Self-checking bench for fpr_regs driven through the host model.
// Assumes the package offsets and reset values of fpr_pkg.
`timescale 1ns/100ps
`default_nettype none
module tb_fpr_regs
    import fpr_pkg::*;
;
    logic clk, rst_b, bacc, pst, v, boost, irq;
    logic [7:0] pa, rdata, d, m, hptr, txb, rxb;
    logic [2:0] gain;
    fpr_req_t req;
    fpr_irq_t ev, flags, pend;
    int n_mismatch = 0;
    int samples_checked = 0;
    fpr_host_model host_u (.i_clock(clk), .i_rdata(rdata),
        .i_rdata_valid(v), .o_req(req));
    fpr_regs dut_u (.i_clock(clk), .i_rst_b(rst_b), .i_req(req),
        .i_buf_access(bacc), .i_rx_pkt_start(pst), .i_rx_pkt_addr(pa),
        .i_irq_event(ev), .o_rdata(rdata), .o_rdata_valid(v),
        .o_front_end_gain_step(gain), .o_high_band_boost(boost),
        .o_host_buffer_pointer(hptr), .o_transmit_buffer_base(txb),
        .o_receive_buffer_base(rxb), .o_irq_flags(flags),
        .o_irq_pending(pend), .o_irq(irq));
    task automatic chk(input string n, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic vs;
        host_u.rd(a, d, vs);
        chk("rdata", d, e);
        chk("valid", {7'h00, vs}, 8'h01);
    endtask
    task automatic pulse(input logic b, p, input fpr_irq_t e);
        @(posedge clk);
        {bacc, pst, ev} <= {b, p, e};
        @(posedge clk);
        {bacc, pst, ev} <= '0;
        #1;
    endtask
    task automatic results;
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        results;
    end
    initial begin
        logic [7:0] rv [8] = '{8'h20, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00};
        {rst_b, bacc, pst, pa, ev} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rchk(7'h0C + 7'(i), rv[i]);
        chk("gain", {5'h00, gain}, 8'h01);
        $display("test reset done");
        host_u.wr(7'h0C, 8'hC3);
        rchk(7'h0C, 8'hC3);
        chk("boost", {gain, 4'h0, boost}, 8'hC1);
        host_u.wr(7'h0C, 8'hE4);
        rchk(7'h0C, 8'hC4);
        chk("boost", {7'h00, boost}, 8'h00);
        $display("test gain done");
        host_u.wr(7'h0D, 8'hFF);
        host_u.wr(7'h0E, 8'h12);
        host_u.wr(7'h0F, 8'h34);
        host_u.wr(7'h10, 8'h55);
        rchk(7'h10, 8'h00);
        pa <= 8'h9A;
        pulse(1'b1, 1'b1, '0);
        rchk(7'h0D, 8'h00);
        chk("bases", txb ^ rxb, 8'h26);
        chk("rxb", rxb, 8'h34);
        rchk(7'h10, 8'h9A);
        $display("test pointers done");
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            host_u.wr(7'h11, m);
            pulse(1'b0, 1'b0, 8'hFF);
            chk("pend", pend, ~m);
            chk("irq_on", {7'h00, irq}, 8'h01);
            host_u.wr(7'h12, ~m);
            chk("flags", flags, m);
            chk("irq", {7'h00, irq}, 8'h00);
            host_u.wr(7'h12, m);
            chk("clear", flags, 8'h00);
        end
        $display("test masks done");
        results;
    end
endmodule // tb_fpr_regs
`default_nettype wire
